/* cpu_bus_model.sv */
`timescale 1ns/100ps
module cpu_bus_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [3:0] addr,
  output logic [7:0] wrData,
  output logic wrStb,
  output logic rdStb,
  input wire logic [7:0] rdData
);
  initial begin
    addr = 4'h0;
    wrData = 8'h00;
    wrStb = 1'h0;
    rdStb = 1'h0;
  end
  // -------------------------
  // Software accesses
  // -------------------------
  // One-cycle strobes; a gap cycle follows each access
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge ref_clk);
    wrStb <= 1'h0;
  endtask
  // Callers read high before low and status before low clear
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge ref_clk);
    rdStb <= 1'h0;
    // Data stands one cycle; taken at the edge that ends it
    @(posedge ref_clk);
    d = rdData;
  endtask
endmodule // cpu_bus_model

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, rst, globalMask, haltMode, capTwoEvent, cmpTwoEvent, extPin;
  logic [3:0] addr;
  logic [7:0] wrData, rdData, rdDataAlt, v;
  logic wrStb, rdStb, timerIrq, countTick;
  logic [15:0] countValue, countValueAlt, c;
  int errors, checked;
  cpu_bus_model bus (.ref_clk(ref_clk), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData));
  timer16_counter dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .globalMask(globalMask), .haltMode(haltMode), .capTwoEvent(capTwoEvent),
    .cmpTwoEvent(cmpTwoEvent), .ext_timer_clock_pin(extPin), .timerIrq(timerIrq), .countValue(countValue),
    .countTick(countTick));
  // Flash variant, clock pin not bonded, same stimulus
  timer16_counter #(.EXT_PIN_BONDED(1'b0), .FLASH_FIRST_TIMER(1'b1)) dutAlt (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdDataAlt), .globalMask(globalMask),
    .haltMode(haltMode), .capTwoEvent(capTwoEvent), .cmpTwoEvent(cmpTwoEvent), .ext_timer_clock_pin(extPin),
    .timerIrq(), .countValue(countValueAlt), .countTick());
  // -------------------------
  // Helpers
  // -------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Freeze first so the reload value is what stays visible
  task automatic freeze_reload;
    @(posedge ref_clk);
    haltMode <= 1'h1;
    bus.wr(timer16_pkg::ADDR_CNT_LOW, 8'h5A);
    #1 check(countValue, 16'hFFFC);
  endtask
  task automatic run;
    @(posedge ref_clk);
    haltMode <= 1'h0;
  endtask
  // Pulses spaced nine cycles, well over four
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      extPin <= 1'h1;
      idle(4);
      extPin <= 1'h0;
      idle(4);
    end
    idle(6);
  endtask
  // -------------------------
  // Scenarios
  // -------------------------
  task automatic t_read_seq;
    freeze_reload();
    bus.rd(timer16_pkg::ADDR_CNT_HIGH, v);
    check(v, 8'hFF);
    run();
    idle(40);
    bus.rd(timer16_pkg::ADDR_CNT_HIGH, v);
    bus.rd(timer16_pkg::ADDR_CNT_LOW, v);
    check(v, 8'hFC);
    bus.rd(timer16_pkg::ADDR_CNT_LOW, v);
    check(v !== 8'hFC, 1'h1);
    freeze_reload();
    bus.rd(timer16_pkg::ADDR_SHD_HIGH, v);
    check(v, 8'hFF);
    bus.rd(timer16_pkg::ADDR_SHD_LOW, v);
    check(v, 8'hFC);
  endtask
  task automatic t_overflow;
    bus.wr(timer16_pkg::ADDR_CTRL_ONE, 8'h20);
    bus.wr(timer16_pkg::ADDR_CTRL_TWO, 8'h08);
    globalMask <= 1'h1;
    freeze_reload();
    bus.rd(timer16_pkg::ADDR_STATUS, v);
    check(v[timer16_pkg::OVF_FLAG_BIT], 1'h1);
    bus.rd(timer16_pkg::ADDR_CNT_LOW, v);
    bus.rd(timer16_pkg::ADDR_STATUS, v);
    check(v[timer16_pkg::OVF_FLAG_BIT], 1'h0);
    run();
    idle(30);
    check(timerIrq, 1'h0);
    bus.rd(timer16_pkg::ADDR_STATUS, v);
    check(v[timer16_pkg::OVF_FLAG_BIT], 1'h1);
    globalMask <= 1'h0;
    #1 check(timerIrq, 1'h1);
    bus.rd(timer16_pkg::ADDR_SHD_LOW, v);
    bus.rd(timer16_pkg::ADDR_STATUS, v);
    check(v[timer16_pkg::OVF_FLAG_BIT], 1'h1);
    bus.rd(timer16_pkg::ADDR_CNT_LOW, v);
    check(timerIrq, 1'h0);
    bus.wr(timer16_pkg::ADDR_CTRL_TWO, 8'h00);
  endtask
  task automatic t_halt;
    @(posedge ref_clk);
    haltMode <= 1'h1;
    idle(2);
    c = countValue;
    idle(50);
    check(countValue, c);
    check(countTick, 1'h0);
    check(countValueAlt, countValue);
    run();
    idle(20);
    check(countValue !== c, 1'h1);
  endtask
  task automatic t_ext;
    bus.wr(timer16_pkg::ADDR_CTRL_TWO, 8'h0D);
    freeze_reload();
    run();
    pulses(3);
    check(countValue, 16'hFFFF);
    check(countValueAlt, 16'hFFFC);
    bus.wr(timer16_pkg::ADDR_CTRL_TWO, 8'h0C);
    freeze_reload();
    run();
    pulses(2);
    check(countValue, 16'hFFFE);
  endtask
  task automatic t_flash;
    @(posedge ref_clk);
    capTwoEvent <= 1'h1;
    cmpTwoEvent <= 1'h1;
    @(posedge ref_clk);
    capTwoEvent <= 1'h0;
    cmpTwoEvent <= 1'h0;
    bus.rd(timer16_pkg::ADDR_STATUS, v);
    check(v[timer16_pkg::CAP2_FLAG_BIT], 1'h1);
    check(v[timer16_pkg::CMP2_FLAG_BIT], 1'h1);
    check(rdDataAlt[timer16_pkg::CAP2_FLAG_BIT], 1'h0);
    check(rdDataAlt[timer16_pkg::CMP2_FLAG_BIT], 1'h0);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Scenarios need under a thousand cycles; five thousand allowed
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  initial begin
    rst = 1'h1;
    globalMask = 1'h0;
    haltMode = 1'h0;
    capTwoEvent = 1'h0;
    cmpTwoEvent = 1'h0;
    extPin = 1'h0;
    idle(2);
    check(countValue, 16'hFFFC);
    rst <= 1'h0;
    t_read_seq();
    t_overflow();
    t_halt();
    t_ext();
    t_flash();
    end_sim();
  end
endmodule // tb_top

/* tick_if.sv */
`timescale 1ns/100ps
interface tick_if;
  logic [1:0] presc;
  logic extEdge;
  logic extPin;
  logic halt;
  logic tick;
  modport gen (input presc, input extEdge, input extPin, input halt, output tick);
  modport use_side (output presc, output extEdge, output extPin, output halt, input tick);
endinterface

/* timer16_counter.sv */
`timescale 1ns/100ps
// Function
// - 16-bit upcounter advanced by clock divided by 2, 4, 8 or external clock.
// - Two views hold same count; shadow low read keeps overflow flag.
// - Writing either low byte forces the counter to FFFCh.
// - Counter starts at FFFCh after reset; FFFCh is the only reload value.
// - Flash variant: compare two write-only, capture two absent, their flags zero.
// - High byte read first latches low byte for the following low read.
// - Latched low byte stays frozen until the low byte is read.
// - After a completed sequence, low-only reads return the live low byte.
// - Roll-over from FFFFh to 0000h sets the overflow flag.
// - Interrupt when flag, enable set and global mask clear; otherwise pending.
// - Flag clears by status read then main low access; shadow low never clears.
// - Counting continues unchanged in WAIT mode.
// - HALT stops the counter; resumes from held count or reset count.
// - Timer inputs on unbonded pins read as logic one.
// - Two instances share nothing and stay synchronised after reset.
// - Both select bits one picks external clock; edge bit picks transition.
// - External edges are synchronised to the internal clock first.
module timer16_counter #(
  parameter bit EXT_PIN_BONDED = 1'b1,
  parameter bit FLASH_FIRST_TIMER = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // System
  input wire logic globalMask,
  input wire logic haltMode,
  input wire logic capTwoEvent,
  input wire logic cmpTwoEvent,
  // Pins
  input wire logic ext_timer_clock_pin,
  // Results
  output logic timerIrq,
  output logic [15:0] countValue,
  output logic countTick
);
  tick_if tk ();
  logic [15:0] count_r;
  logic [7:0] ctrlOne_r;
  logic [7:0] ctrlTwo_r;
  logic ovfFlag_r;
  logic statusArmed_r;
  logic [7:0] lowBuf_r;
  logic seqOpen_r;
  logic capTwoFlag_r;
  logic cmpTwoFlag_r;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic lowWrite;
  logic mainLowAcc;
  logic rollOver;
  logic ovfClear;
  logic highRead;
  logic lowRead;

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  assign tk.presc = ctrlTwo_r[timer16_pkg::PRESC_LSB +: 2];
  assign tk.extEdge = ctrlTwo_r[timer16_pkg::EXT_EDGE_BIT];
  assign tk.extPin = EXT_PIN_BONDED ? ext_timer_clock_pin : 1'b1;
  assign tk.halt = haltMode;

  timer16_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tk(tk.gen)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign lowWrite = wrStb && (addr == timer16_pkg::ADDR_CNT_LOW || addr == timer16_pkg::ADDR_SHD_LOW);
  assign mainLowAcc = (wrStb || rdStb) && addr == timer16_pkg::ADDR_CNT_LOW;
  assign highRead = rdStb && (addr == timer16_pkg::ADDR_CNT_HIGH || addr == timer16_pkg::ADDR_SHD_HIGH);
  assign lowRead = rdStb && (addr == timer16_pkg::ADDR_CNT_LOW || addr == timer16_pkg::ADDR_SHD_LOW);
  assign rollOver = tk.tick && !lowWrite && count_r == timer16_pkg::COUNT_TOP;
  assign ovfClear = statusArmed_r && mainLowAcc;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Instances share no state, so equal resets keep them in step
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_r <= timer16_pkg::COUNT_RELOAD;
    end else if (lowWrite) begin
      count_r <= timer16_pkg::COUNT_RELOAD;
    end else if (tk.tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlOne_r <= timer16_pkg::CTRL_RESET;
      ctrlTwo_r <= timer16_pkg::CTRL_RESET;
    end else if (wrStb) begin
      if (addr == timer16_pkg::ADDR_CTRL_ONE) begin
        ctrlOne_r <= wrData;
      end
      if (addr == timer16_pkg::ADDR_CTRL_TWO) begin
        ctrlTwo_r <= wrData;
      end
    end
  end

  // ----------------------------------------
  // Overflow flag
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovfFlag_r <= 1'b0;
    end else if (rollOver) begin
      ovfFlag_r <= 1'b1;
    end else if (ovfClear) begin
      ovfFlag_r <= 1'b0;
    end
  end

  // Status read only arms the clear while the flag is seen set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      statusArmed_r <= 1'b0;
    end else if (rdStb && addr == timer16_pkg::ADDR_STATUS) begin
      statusArmed_r <= ovfFlag_r;
    end else if (mainLowAcc) begin
      statusArmed_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Second channel flags
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capTwoFlag_r <= 1'b0;
      cmpTwoFlag_r <= 1'b0;
    end else if (FLASH_FIRST_TIMER) begin
      capTwoFlag_r <= 1'b0;
      cmpTwoFlag_r <= 1'b0;
    end else begin
      capTwoFlag_r <= capTwoFlag_r | capTwoEvent;
      cmpTwoFlag_r <= cmpTwoFlag_r | cmpTwoEvent;
    end
  end

  // ----------------------------------------
  // Read sequence
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seqOpen_r <= 1'b0;
      lowBuf_r <= 8'h00;
    end else if (highRead && !seqOpen_r) begin
      seqOpen_r <= 1'b1;
      lowBuf_r <= count_r[7:0];
    end else if (lowRead) begin
      seqOpen_r <= 1'b0;
    end
  end

  always_comb begin
    rdData_nxt = 8'h00;
    unique case (addr)
      timer16_pkg::ADDR_CTRL_ONE: rdData_nxt = ctrlOne_r;
      timer16_pkg::ADDR_CTRL_TWO: rdData_nxt = ctrlTwo_r;
      timer16_pkg::ADDR_STATUS: begin
        rdData_nxt[timer16_pkg::OVF_FLAG_BIT] = ovfFlag_r;
        rdData_nxt[timer16_pkg::CAP2_FLAG_BIT] = capTwoFlag_r;
        rdData_nxt[timer16_pkg::CMP2_FLAG_BIT] = cmpTwoFlag_r;
      end
      timer16_pkg::ADDR_CNT_HIGH, timer16_pkg::ADDR_SHD_HIGH: rdData_nxt = count_r[15:8];
      timer16_pkg::ADDR_CNT_LOW, timer16_pkg::ADDR_SHD_LOW: rdData_nxt = seqOpen_r ? lowBuf_r : count_r[7:0];
      default: rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (rdStb) begin
      rdData_r <= rdData_nxt;
    end else begin
      rdData_r <= 8'h00;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdData = rdData_r;
  assign timerIrq = ovfFlag_r && ctrlOne_r[timer16_pkg::OVF_IE_BIT] && !globalMask;
  assign countValue = count_r;
  assign countTick = tk.tick;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reload;
    @(posedge ref_clk) disable iff (rst) lowWrite |=> count_r == timer16_pkg::COUNT_RELOAD;
  endproperty
  a_reload: assert property (p_reload) else $error("low write did not reload");

  property p_roll;
    @(posedge ref_clk) disable iff (rst) rollOver |=> ovfFlag_r && count_r == 16'h0000;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover lost");

  property p_shadow;
    @(posedge ref_clk) disable iff (rst)
      (rdStb && addr == timer16_pkg::ADDR_SHD_LOW && ovfFlag_r && !rollOver) |=> ovfFlag_r;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow low cleared flag");

  // Pending request must survive the mask and show once unmasked
  property p_irq;
    @(posedge ref_clk) disable iff (rst)
      (ovfFlag_r && ctrlOne_r[timer16_pkg::OVF_IE_BIT] && globalMask && !ovfClear
        && !(wrStb && addr == timer16_pkg::ADDR_CTRL_ONE)) ##1 !globalMask |-> timerIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_frozen;
    @(posedge ref_clk) disable iff (rst)
      (seqOpen_r && !lowRead) |=> $stable(lowBuf_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("buffer moved");

  property p_halt;
    @(posedge ref_clk) disable iff (rst) (haltMode && !lowWrite) |=> $stable(count_r);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved in halt");

  property p_live;
    @(posedge ref_clk) disable iff (rst)
      (rdStb && addr == timer16_pkg::ADDR_CNT_LOW && !seqOpen_r) |=> rdData == $past(count_r[7:0]);
  endproperty
  a_live: assert property (p_live) else $error("low read not live");

  property p_latch;
    @(posedge ref_clk) disable iff (rst)
      (highRead && !seqOpen_r) |=> seqOpen_r && lowBuf_r == $past(count_r[7:0]);
  endproperty
  a_latch: assert property (p_latch) else $error("low byte not latched");

  property p_flash;
    @(posedge ref_clk) disable iff (rst) FLASH_FIRST_TIMER |=> !capTwoFlag_r && !cmpTwoFlag_r;
  endproperty
  a_flash: assert property (p_flash) else $error("flash flags set");

  property p_step;
    @(posedge ref_clk) disable iff (rst) (tk.tick && !lowWrite) |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count did not step by one");

  property p_div2;
    @(posedge ref_clk) disable iff (rst) (tk.tick && tk.presc == timer16_pkg::PRESC_DIV2 && !wrStb) |=> !tk.tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice");

  property p_close;
    @(posedge ref_clk) disable iff (rst) lowRead |=> !seqOpen_r;
  endproperty
  a_close: assert property (p_close) else $error("low read left sequence open");

  property p_clear;
    @(posedge ref_clk) disable iff (rst) (ovfClear && !rollOver) |=> !ovfFlag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_arm;
    @(posedge ref_clk) disable iff (rst) (rdStb && addr == timer16_pkg::ADDR_STATUS) |=> statusArmed_r == $past(ovfFlag_r);
  endproperty
  a_arm: assert property (p_arm) else $error("status read armed wrongly");

  property p_high_view;
    @(posedge ref_clk) disable iff (rst) highRead |=> rdData == $past(count_r[15:8]);
  endproperty
  a_high_view: assert property (p_high_view) else $error("high view wrong");

  property p_unbonded;
    @(posedge ref_clk) disable iff (rst) (!EXT_PIN_BONDED && tk.presc == timer16_pkg::PRESC_EXT) |-> !tk.tick;
  endproperty
  a_unbonded: assert property (p_unbonded) else $error("unbonded pin ticked");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (rst) (ovfFlag_r && !ovfClear) |=> ovfFlag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("pending flag lost");
endmodule // timer16_counter

/* timer16_pkg.sv */
package timer16_pkg;
  // Register offsets on the plain port (byte addresses)
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CNT_LOW = 4'h4;
  localparam logic [3:0] ADDR_SHD_HIGH = 4'h5;
  localparam logic [3:0] ADDR_SHD_LOW = 4'h6;
  // Field positions
  localparam int OVF_IE_BIT = 5;
  localparam int OVF_FLAG_BIT = 5;
  localparam int CAP2_FLAG_BIT = 4;
  localparam int CMP2_FLAG_BIT = 3;
  localparam int EXT_EDGE_BIT = 0;
  localparam int PRESC_LSB = 2;
  // Reset, reload and roll-over values
  localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Prescale select codes
  typedef enum logic [1:0] {
    PRESC_DIV4 = 2'b00,
    PRESC_DIV8 = 2'b01,
    PRESC_DIV2 = 2'b10,
    PRESC_EXT = 2'b11
  } presc_t;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
endpackage

/* timer16_tick_gen.sv */
`timescale 1ns/100ps
module timer16_tick_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Tick channel
  tick_if.gen tk
);
  logic [2:0] div_r;
  logic pinSync_r;
  logic pinOld_r;
  logic [2:0] mask;
  logic extHit;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 3'h0;
    end else if (!tk.halt) begin
      div_r <= div_r + 3'h1;
    end
  end

  // ----------------------------------------
  // External clock edge
  // ----------------------------------------
  // Pin is synchronised to ref_clk first; two stages register it for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinSync_r <= 1'b1;
      pinOld_r <= 1'b1;
    end else begin
      pinSync_r <= tk.extPin;
      pinOld_r <= pinSync_r;
    end
  end

  assign extHit = tk.extEdge ? (pinSync_r && !pinOld_r) : (!pinSync_r && pinOld_r);

  always_comb begin
    unique case (timer16_pkg::presc_t'(tk.presc))
      timer16_pkg::PRESC_DIV2: mask = timer16_pkg::DIV2_MASK;
      timer16_pkg::PRESC_DIV4: mask = timer16_pkg::DIV4_MASK;
      timer16_pkg::PRESC_DIV8: mask = timer16_pkg::DIV8_MASK;
      timer16_pkg::PRESC_EXT: mask = timer16_pkg::DIV2_MASK;
    endcase
  end

  assign tk.tick = !tk.halt && ((tk.presc == timer16_pkg::PRESC_EXT) ? extHit : ((div_r & mask) == mask));
endmodule // timer16_tick_gen
